// file: common/smbx_pkg.sv
/*
  Shared constants and types for the two-wire bus extension block: command
  and address byte codes, timing figures and protocol state encodings.
  Assumes a 100 MHz system clock and a free-running link sampling clock.
*/
package smbx_pkg;

  // ----------------------------------------------------------------------
  // Byte codes on the bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] SMBX_SET_PROTECT = 8'h62;
  localparam logic [7:0] SMBX_CLR_PROTECT = 8'h66;
  localparam logic [7:0] SMBX_CHK_PROTECT = 8'h63;
  localparam logic [7:0] SMBX_ALERT_QUERY = 8'h19;
  localparam logic [7:0] SMBX_GEN_CALL = 8'h00;
  localparam logic [7:0] SMBX_GC_RELATCH = 8'h04;
  localparam logic [7:0] SMBX_GC_RESET = 8'h06;
  localparam logic [3:0] SMBX_DEV_TYPE = 4'h9;

  // ----------------------------------------------------------------------
  // Event toggle positions crossing from link to system domain
  // ----------------------------------------------------------------------
  localparam int SMBX_EV_SET = 0;
  localparam int SMBX_EV_CLR = 1;
  localparam int SMBX_EV_ARA = 2;
  localparam int SMBX_EV_GCR = 3;

  // ----------------------------------------------------------------------
  // Timing: figures in their own units, counts derived from the clock
  // ----------------------------------------------------------------------
  localparam int SMBX_CLK_MHZ = 100;
  localparam int SMBX_TIMEOUT_MIN_US = 25000;
  localparam int SMBX_POR_MAX_US = 1000;
  localparam int SMBX_TIMEOUT_CYC = SMBX_TIMEOUT_MIN_US * SMBX_CLK_MHZ + 1;
  localparam int SMBX_POR_CYC = SMBX_POR_MAX_US * SMBX_CLK_MHZ;

  // ----------------------------------------------------------------------
  // Protocol states and byte roles
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_ACKH, ST_TX, ST_SKIP} smbx_st_e;
  typedef enum logic [2:0] {OP_ADDR, OP_SETA, OP_SETD, OP_CLRA, OP_CLRD, OP_GCC, OP_ARA,
                            OP_DONE} smbx_op_e;

endpackage : smbx_pkg

// file: hdl/smbx_slave_ext.sv
/*
  Slave-side bus extensions: reversible array protection, alert response
  arbitration, clock-low timeout and general call relatch/reset.
  Assumes scl/sda and address pins are asynchronous to both clocks and that
  link_clk runs freely, well above the bus bit rate.
*/
`timescale 1ns/1ns

// Notes on behaviour
// - Set protect sequence 62h acked with pins
// - Protection blocks every array write
// - Clear protect 66h sequence ends with stop
// - Status byte 63h nacked when protected
// - Address and data bytes are don't-care
// - Alert only in interrupt, active-low mode
// - Alerting device acks query byte 19h
// - Answer sends 1001 plus latched pins
// - Last bit one high, zero low
// - Bitwise open-drain arbitration, lowest wins
// - Winner drops alert after address byte
// - Loser releases, no ack, keeps alert
// - Long clock-low resets interface, releases data
// - Fresh start accepted before maximum timeout
// - General call 00h acked, awaits command
// - Command 04h relatches address pins
// - Command 06h relatches and copies registers
// - Busy during copy, bounded by reset time
module smbx_slave_ext
  import smbx_pkg::*;
#(
  parameter int TIMEOUT_CYC = SMBX_TIMEOUT_CYC,
  parameter int POR_CYC = SMBX_POR_CYC
)(
  // System clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link sampling clock
  input wire logic link_clk,
  // Bus pins
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address pins and high-voltage qualifier
  input wire logic address_pin_two,
  input wire logic address_pin_one,
  input wire logic address_pin_zero,
  input wire logic pin_zero_high_voltage_qualifier,
  // Alarm configuration and events
  input wire logic comparator_interrupt_select,
  input wire logic alarm_polarity,
  input wire logic alarm_high_event,
  input wire logic alarm_low_event,
  output logic alert_o,
  output logic alert_oe,
  // Array write gate and register copy
  input wire logic eeprom_write_req,
  output logic eeprom_write_grant,
  output logic reversible_array_protect,
  output logic nv_copy_start,
  output logic busy,
  output logic [2:0] latched_address
);

  // ----------------------------------------------------------------------
  // Link domain: pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [9:0] ls1_q, ls2_q;
  logic scl_s, sda_s, a2_s, a1_s, a0_s, hv_s, alert_s, lim_s, prot_s, tmo_s;
  logic scl_p_q, sda_p_q;
  logic start, stop, scl_rise, scl_fall;
  logic alert_q, lim_q, prot_q, tmo_q;

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ls1_q <= 10'h300;
      ls2_q <= 10'h300;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      ls1_q <= {scl, sda_i, address_pin_two, address_pin_one, address_pin_zero,
                pin_zero_high_voltage_qualifier, alert_q, lim_q, prot_q, tmo_q};
      ls2_q <= ls1_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign {scl_s, sda_s, a2_s, a1_s, a0_s, hv_s, alert_s, lim_s, prot_s, tmo_s} = ls2_q;
  assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;

  // Pin pattern that qualifies a protection sequence; a1 selects set or clear.
  function automatic logic wp_pins(input logic a1_want, input logic a2, input logic a1,
                                   input logic hv);
    wp_pins = !a2 && (a1 == a1_want) && hv;
  endfunction : wp_pins

  // ----------------------------------------------------------------------
  // Link domain: protocol state machine
  // ----------------------------------------------------------------------
  smbx_st_e st_q, st_d;
  smbx_op_e op_q, op_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, rx_b;
  logic ack_q, ack_d, oe_q, oe_d, clrp_q, clrp_d;
  logic [3:0] ev_t_q, ev_t_d;
  logic [2:0] addr_q, addr_d, aok_q, aok_d;

  assign rx_b = {sh_q[6:0], sda_s};

  // Next-state logic; start and stop override every state, timeout overrides all.
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ack_d = ack_q;
    oe_d = oe_q;
    clrp_d = clrp_q;
    ev_t_d = ev_t_q;
    addr_d = addr_q;
    aok_d = {aok_q[1:0], 1'b1};
    if (!aok_q[2]) // The synchroniser holds reset levels for the first two edges.
      addr_d = {a2_s, a1_s, a0_s};
    if (tmo_s)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      clrp_d = 1'b0;
    end
    else if (start)
    begin
      st_d = ST_RX;
      op_d = OP_ADDR;
      cnt_d = 3'h0;
      oe_d = 1'b0;
      clrp_d = 1'b0;
    end
    else if (stop)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      if (clrp_q)
        ev_t_d[SMBX_EV_CLR] = ~ev_t_q[SMBX_EV_CLR];
      clrp_d = 1'b0;
    end
    else
    begin
      case (st_q)
        ST_RX:
          if (scl_rise)
          begin
            sh_d = rx_b;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7)
            begin
              st_d = ST_ACK;
              ack_d = 1'b1;
              op_d = OP_DONE;
              case (op_q)
                OP_ADDR:
                begin
                  ack_d = 1'b0;
                  if (rx_b == SMBX_SET_PROTECT && wp_pins(1'b0, a2_s, a1_s, hv_s))
                  begin
                    ack_d = 1'b1;
                    op_d = OP_SETA;
                  end
                  if (rx_b == SMBX_CLR_PROTECT && wp_pins(1'b1, a2_s, a1_s, hv_s))
                  begin
                    ack_d = 1'b1;
                    op_d = OP_CLRA;
                  end
                  if (rx_b == SMBX_CHK_PROTECT)
                    ack_d = !prot_s;
                  if (rx_b == SMBX_ALERT_QUERY && alert_s)
                  begin
                    ack_d = 1'b1;
                    op_d = OP_ARA;
                  end
                  if (rx_b == SMBX_GEN_CALL)
                  begin
                    ack_d = 1'b1;
                    op_d = OP_GCC;
                  end
                end
                OP_SETA:
                begin
                  ack_d = wp_pins(1'b0, a2_s, a1_s, hv_s);
                  op_d = OP_SETD;
                end
                OP_SETD:
                begin
                  ack_d = wp_pins(1'b0, a2_s, a1_s, hv_s);
                  if (ack_d)
                    ev_t_d[SMBX_EV_SET] = ~ev_t_q[SMBX_EV_SET];
                end
                OP_CLRA:
                begin
                  ack_d = wp_pins(1'b1, a2_s, a1_s, hv_s);
                  op_d = OP_CLRD;
                end
                OP_CLRD:
                begin
                  ack_d = wp_pins(1'b1, a2_s, a1_s, hv_s);
                  clrp_d = ack_d;
                end
                OP_GCC:
                begin
                  if (rx_b == SMBX_GC_RELATCH || rx_b == SMBX_GC_RESET)
                    addr_d = {a2_s, a1_s, a0_s};
                  if (rx_b == SMBX_GC_RESET)
                    ev_t_d[SMBX_EV_GCR] = ~ev_t_q[SMBX_EV_GCR];
                end
                default: ack_d = 1'b0;
              endcase
            end
          end
        ST_ACK:
          if (scl_fall)
          begin
            oe_d = ack_q;
            st_d = ack_q ? ST_ACKH : ST_SKIP;
          end
        ST_ACKH:
          if (scl_fall)
          begin
            cnt_d = 3'h0;
            oe_d = 1'b0;
            st_d = (op_q == OP_DONE) ? ST_SKIP : ST_RX;
            if (op_q == OP_ARA)
            begin
              sh_d = {SMBX_DEV_TYPE, addr_q, lim_s};
              oe_d = !SMBX_DEV_TYPE[3];
              st_d = ST_TX;
            end
          end
        ST_TX:
          if (scl_rise && !oe_q && !sda_s)
            st_d = ST_SKIP;
          else if (scl_fall)
          begin
            cnt_d = cnt_q + 3'h1;
            sh_d = {sh_q[6:0], 1'b1};
            oe_d = !sh_q[6];
            if (cnt_q == 3'h7)
            begin
              oe_d = 1'b0;
              st_d = ST_SKIP;
              ev_t_d[SMBX_EV_ARA] = ~ev_t_q[SMBX_EV_ARA];
            end
          end
        default: st_d = st_q;
      endcase
    end
  end

  // Protocol registers.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      op_q <= OP_ADDR;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      clrp_q <= 1'b0;
      ev_t_q <= 4'h0;
      addr_q <= 3'h0;
      aok_q <= 3'h0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      clrp_q <= clrp_d;
      ev_t_q <= ev_t_d;
      addr_q <= addr_d;
      aok_q <= aok_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign latched_address = addr_q;

  // ----------------------------------------------------------------------
  // System domain: crossings, protection, alert, timeout, reset copy
  // ----------------------------------------------------------------------
  logic [4:0] cs1_q, cs2_q;
  logic [3:0] t3_q, ev;
  logic alert_d, lim_d, prot_d, tmo_d, copy_q, copy_d;
  logic [23:0] tcnt_q, tcnt_d, bcnt_q, bcnt_d;

  // Toggle edges are taken between the second and third stages only.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs1_q <= 5'h10;
      cs2_q <= 5'h10;
      t3_q <= 4'h0;
    end
    else
    begin
      cs1_q <= {scl, ev_t_q};
      cs2_q <= cs1_q;
      t3_q <= cs2_q[3:0];
    end
  end

  assign ev = cs2_q[3:0] ^ t3_q;

  // Alarm events win over the clear from a won query so none is lost.
  always_comb
  begin
    prot_d = prot_q;
    if (ev[SMBX_EV_SET])
      prot_d = 1'b1;
    else if (ev[SMBX_EV_CLR])
      prot_d = 1'b0;
    alert_d = alert_q;
    lim_d = lim_q;
    if (alarm_high_event || alarm_low_event)
    begin
      alert_d = 1'b1;
      lim_d = alarm_high_event;
    end
    else if (ev[SMBX_EV_ARA])
      alert_d = 1'b0;
    tcnt_d = 24'h000000;
    tmo_d = 1'b0;
    if (!cs2_q[4])
    begin
      tmo_d = tmo_q || (tcnt_q == 24'(TIMEOUT_CYC));
      tcnt_d = tmo_d ? tcnt_q : tcnt_q + 24'h000001;
    end
    copy_d = ev[SMBX_EV_GCR];
    bcnt_d = (bcnt_q != 24'h000000) ? bcnt_q - 24'h000001 : bcnt_q;
    if (copy_d)
      bcnt_d = 24'(POR_CYC);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prot_q <= 1'b0;
      alert_q <= 1'b0;
      lim_q <= 1'b0;
      tcnt_q <= 24'h000000;
      tmo_q <= 1'b0;
      copy_q <= 1'b0;
      bcnt_q <= 24'h000000;
    end
    else
    begin
      prot_q <= prot_d;
      alert_q <= alert_d;
      lim_q <= lim_d;
      tcnt_q <= tcnt_d;
      tmo_q <= tmo_d;
      copy_q <= copy_d;
      bcnt_q <= bcnt_d;
    end
  end

  // Alert pin is open drain; it is driven only in SMBus alert mode.
  assign alert_o = 1'b0;
  assign alert_oe = alert_q && comparator_interrupt_select && !alarm_polarity;
  assign eeprom_write_grant = eeprom_write_req && !prot_q;
  assign reversible_array_protect = prot_q;
  assign nv_copy_start = copy_q;
  assign busy = bcnt_q != 24'h000000;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_write_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    prot_q |-> !eeprom_write_grant) else $error("Write granted while protected.");
  a_alert_mode: assert property (@(posedge clk) disable iff (!rst_n)
    alert_oe |-> comparator_interrupt_select && !alarm_polarity)
    else $error("Alert driven outside alert mode.");
  a_winner_clears: assert property (@(posedge clk) disable iff (!rst_n)
    ev[SMBX_EV_ARA] && !alarm_high_event && !alarm_low_event |=> !alert_q)
    else $error("Alert not cleared after win.");
  a_timeout_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tmo_q) |-> tcnt_q == 24'(TIMEOUT_CYC) && !$past(cs2_q[4], 2))
    else $error("Timeout raised at wrong count.");
  a_busy_bound: assert property (@(posedge clk) disable iff (!rst_n)
    copy_q |-> busy && bcnt_q == 24'(POR_CYC)) else $error("Busy length wrong.");
  a_tmo_release: assert property (@(posedge link_clk) disable iff (!rst_n)
    tmo_s |=> st_q == ST_IDLE && !sda_oe) else $error("Timeout did not release bus.");
  a_chk_nack: assert property (@(posedge link_clk) disable iff (!rst_n)
    st_q == ST_RX && op_q == OP_ADDR && scl_rise && cnt_q == 3'h7 && !tmo_s && !start &&
    !stop && rx_b == SMBX_CHK_PROTECT |=> ack_q == !$past(prot_s))
    else $error("Status byte answer wrong.");
  a_ara_ignored: assert property (@(posedge link_clk) disable iff (!rst_n)
    st_q == ST_RX && op_q == OP_ADDR && scl_rise && cnt_q == 3'h7 && !alert_s &&
    rx_b == SMBX_ALERT_QUERY |=> !ack_q) else $error("Query acked without alert.");
  a_loser_quiet: assert property (@(posedge link_clk) disable iff (!rst_n)
    st_q == ST_TX && scl_rise && !oe_q && !sda_s && !tmo_s && !start && !stop
    |=> (st_q == ST_SKIP && !sda_oe) [*2]) else $error("Loser kept driving.");

endmodule : smbx_slave_ext

// file: testbench/smbx_bus_master.sv
/*
  Bus master model with a built-in rival slave for alert arbitration.
  Assumes the bench resolves SDA with a pull-up from every pull-down.
*/
`timescale 1ns/1ns
module smbx_bus_master (
  // Clock and bus
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull,
  // Observed results
  output logic res_valid,
  output logic [7:0] res_val
);
  // ----------------------------------------------------------------------
  // Bit and byte level
  // ----------------------------------------------------------------------
  // Phases of 30 system cycles stay well above three link periods.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    res_valid = 1'b0;
    res_val = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Data moves only while the clock is low, after a short hold time.
  task automatic bit_x(input logic b, output logic r);
    wt(8);
    sda_pull <= !b;
    wt(22);
    scl <= 1'b1;
    wt(30);
    r = sda;
    scl <= 1'b0;
  endtask : bit_x

  task automatic start();
    wt(8);
    sda_pull <= 1'b0;
    wt(22);
    scl <= 1'b1;
    wt(30);
    sda_pull <= 1'b1;
    wt(30);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    wt(8);
    sda_pull <= 1'b1;
    wt(22);
    scl <= 1'b1;
    wt(30);
    sda_pull <= 1'b0;
    wt(30);
  endtask : stop

  task automatic emit(input logic [7:0] v);
    res_val <= v;
    res_valid <= 1'b1;
    @(posedge clk);
    res_valid <= 1'b0;
  endtask : emit

  task automatic wr_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    emit({7'h00, r});
  endtask : wr_byte

  // The rival pulls low where its own answer has zeros, then the master nacks.
  task automatic rd_byte(input logic [7:0] rival);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(!rival[i], v[i]);
    bit_x(1'b1, r);
    emit(v);
  endtask : rd_byte
endmodule : smbx_bus_master

// file: testbench/smbx_slave_ext_test.sv
/*
  Self-checking bench: protection, alert answer, general call, timeout.
  Assumes short timeout and reset counts set through the parameters.
*/
`timescale 1ns/1ns
module smbx_slave_ext_test
  import smbx_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals, clocks and instances
  // ----------------------------------------------------------------------
  localparam int TO_CYC = 200;
  localparam int POR = 50;
  localparam logic [7:0] ACK = 8'h00;
  localparam logic [7:0] NAK = 8'h01;
  logic clk, link_clk, rst_n, scl, sda_line, sda_o, sda_oe, m_pull;
  logic p2, p1, p0, hv, cis, apol, hi_ev, lo_ev, alert_o, alert_oe;
  logic wreq, wgrant, prot, nvc, busy, res_valid, r;
  logic [2:0] laddr;
  logic [7:0] res_val;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h20371442;
  int errors = 0;
  int cmp_count = 0;
  int busy_cyc = 0;
  int copies = 0;

  // SDA idles high through the pull-up; any party may pull it low.
  assign sda_line = !m_pull & !(sda_oe & !sda_o);

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Link clock is offset so its phase is unrelated to the system clock.
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  smbx_slave_ext #(.TIMEOUT_CYC(TO_CYC), .POR_CYC(POR)) i_dut (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .scl(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_pin_two(p2), .address_pin_one(p1), .address_pin_zero(p0),
    .pin_zero_high_voltage_qualifier(hv), .comparator_interrupt_select(cis),
    .alarm_polarity(apol), .alarm_high_event(hi_ev), .alarm_low_event(lo_ev),
    .alert_o(alert_o), .alert_oe(alert_oe), .eeprom_write_req(wreq),
    .eeprom_write_grant(wgrant), .reversible_array_protect(prot),
    .nv_copy_start(nvc), .busy(busy), .latched_address(laddr)
  );

  smbx_bus_master i_master (
    .clk(clk), .sda(sda_line), .scl(scl), .sda_pull(m_pull),
    .res_valid(res_valid), .res_val(res_val)
  );

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] b, input logic [7:0] e);
    exp_q.push_back(e);
    i_master.wr_byte(b);
  endtask : wr

  task automatic rd(input logic [7:0] rival, input logic [7:0] e);
    exp_q.push_back(e);
    i_master.rd_byte(rival);
  endtask : rd

  task automatic pins(input logic [3:0] v);
    @(posedge clk);
    {p2, p1, p0, hv} <= v;
  endtask : pins

  task automatic ev(input logic hi);
    @(posedge clk);
    hi_ev <= hi;
    lo_ev <= !hi;
    @(posedge clk);
    hi_ev <= 1'b0;
    lo_ev <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : ev

  // Each bus result is matched against the oldest expectation noted.
  always @(posedge clk)
  begin
    if (res_valid === 1'b1)
      check("bus result", res_val, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    if (busy === 1'b1)
      busy_cyc++;
    if (nvc === 1'b1)
      copies++;
  end

  // A hang anywhere ends the run as a failure.
  initial
  begin
    repeat (90000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    {p2, p1, p0, hv} = 4'b1010;
    {cis, apol, hi_ev, lo_ev, wreq} = 5'b10001;
    repeat (12) @(posedge clk);
    check("reset outputs", {prot, busy, alert_oe, sda_oe}, 0);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    check("latched address", laddr, 3'b101);
    i_master.start();
    wr(SMBX_CHK_PROTECT, ACK);
    i_master.stop();
    pins(4'b0111);
    i_master.start();
    wr(SMBX_SET_PROTECT, NAK);
    i_master.stop();
    pins(4'b0011);
    i_master.start();
    wr(SMBX_SET_PROTECT, ACK);
    wr(xs(), ACK);
    wr(xs(), ACK);
    i_master.stop();
    check("protect set", prot, 1);
    check("write gate", wgrant, 0);
    i_master.start();
    wr(SMBX_CHK_PROTECT, NAK);
    i_master.stop();
    pins(4'b0111);
    i_master.start();
    wr(SMBX_CLR_PROTECT, ACK);
    wr(xs(), ACK);
    wr(xs(), ACK);
    check("protect before stop", prot, 1);
    i_master.stop();
    check("protect cleared", prot, 0);
    check("write open", wgrant, 1);
    ev(1'b0);
    // Only interrupt mode with active-low polarity may drive the alert.
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      {cis, apol} <= m[1:0];
      repeat (6) @(posedge clk);
      check("alert mode", alert_oe, m == 2);
    end
    // Back to alert mode so the queries below see the pin driven.
    @(posedge clk);
    {cis, apol} <= 2'b10;
    repeat (6) @(posedge clk);
    i_master.start();
    wr(SMBX_ALERT_QUERY, ACK);
    rd(8'h66, 8'h99);
    i_master.stop();
    check("loser alert", {alert_oe, alert_o}, 2'b10);
    i_master.start();
    wr(SMBX_ALERT_QUERY, ACK);
    rd(8'h00, 8'h9a);
    i_master.stop();
    check("winner alert", alert_oe, 0);
    i_master.start();
    wr(SMBX_ALERT_QUERY, NAK);
    i_master.stop();
    ev(1'b1);
    i_master.start();
    wr(SMBX_ALERT_QUERY, ACK);
    rd(8'h00, 8'h9b);
    i_master.stop();
    pins(4'b0100);
    i_master.start();
    wr(8'h01, NAK);
    i_master.stop();
    i_master.start();
    wr(SMBX_GEN_CALL, ACK);
    wr(SMBX_GC_RELATCH, ACK);
    i_master.stop();
    check("relatch", laddr, 3'b010);
    check("no copy yet", copies, 0);
    pins(4'b1100);
    i_master.start();
    wr(SMBX_GEN_CALL, ACK);
    wr(SMBX_GC_RESET, ACK);
    i_master.stop();
    repeat (POR + 20) @(posedge clk);
    check("reset relatch", laddr, 3'b110);
    check("copy pulses", copies, 1);
    check("busy length", busy_cyc, POR);
    // Hold the clock low while the acknowledge of a byte is driven.
    i_master.start();
    for (int i = 7; i >= 0; i--) i_master.bit_x(SMBX_CHK_PROTECT[i], r);
    repeat (60) @(posedge clk);
    check("ack held", sda_oe, 1);
    repeat (TO_CYC + 60) @(posedge clk);
    check("timeout release", sda_oe, 0);
    check("kept state", {prot, laddr}, 4'b0110);
    i_master.start();
    wr(SMBX_CHK_PROTECT, ACK);
    i_master.stop();
    repeat (20) @(posedge clk);
    check("results drained", exp_q.size(), 0);
    tally_and_finish();
  end
endmodule : smbx_slave_ext_test
